// ### arb_pkg.sv
package arb_pkg;

    // Physical address width of the bus.
    localparam int ADDR_W      = 36;
    // Lowest address bit that takes part in a snoop compare (32-byte lines).
    localparam int LINE_LSB    = 5;
    // Number of tag entries held by the snoop filter.
    localparam int SNOOP_LINES = 16;
    // Active-low lines: values for asserted and deasserted.
    localparam logic ACT   = 1'h0;
    localparam logic INACT = 1'h1;

    // Current owner of the bus; the core owns it when no grant is active.
    typedef enum logic [2:0] {
        OWN_CORE,
        OWN_GEN,
        OWN_DUAL,
        OWN_PGEN,
        OWN_PDUAL
    } owner_e;

endpackage

// ### snoop_tags.sv
`timescale 1ns/1ps
// Fully associative line-address store with snoop invalidation.
module snoop_tags #(
    parameter int LINES = arb_pkg::SNOOP_LINES,
    parameter int TAG_W = arb_pkg::ADDR_W - arb_pkg::LINE_LSB
) (
    // Clock and reset.
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // Fill port from the core's cache controller.
    input  wire logic                     fill_valid,
    input  wire logic [TAG_W-1:0]         fill_tag,
    input  wire logic [$clog2(LINES)-1:0] fill_index,
    // Snoop lookup port.
    input  wire logic                     lookup,
    input  wire logic [TAG_W-1:0]         lookup_tag,
    // Lookup result and entry valid vector.
    output logic                          hit,
    output logic [LINES-1:0]              valid
);
    import arb_pkg::*;

    // Registered state of the store.
    typedef struct packed {
        logic [LINES-1:0][TAG_W-1:0] tag;
        logic [LINES-1:0]            vld;
        logic                        hit;
    } tags_s;

    tags_s st;
    tags_s next_st;

    // A fill and a snoop on the same entry in one cycle: the snoop wins,
    // since leaving a stale line valid would break coherency.
    always_comb begin
        next_st = st;
        next_st.hit = 1'h0;
        if (fill_valid) begin
            next_st.tag[fill_index] = fill_tag;
            next_st.vld[fill_index] = 1'h1;
        end
        if (lookup) begin
            for (int i = 0; i < LINES; i++) begin
                if (st.vld[i] && st.tag[i] == lookup_tag) begin
                    next_st.vld[i] = 1'h0;
                    next_st.hit = 1'h1;
                end
            end
        end
    end

    // Valid bits, tags and the hit flag all clear on reset.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hit   = st.hit;
    assign valid = st.vld;
endmodule

// ### bus_arbiter.sv
`timescale 1ns/1ps
// Summary of operation
// - Fixed priority: pdual, steal, pgen, dual, gen.
// - Higher request than owner raises release; steal spares a dual owner.
// - General owner kept while nothing outranks it and it still requests or is active.
// - Request, grant, release lines are active low.
// - Asserted grant names owner; none means core.
// - Snoop strobe sampled every clock edge.
// - Snoop inputs valid only under dual grants.
// - Valid snoop compares bits 35..5, invalidates hits.
// - Deasserted strobe leaves the cache unchanged.
// - Idle bus goes to highest pending requester.
// - After owner drops active, release drops.
module bus_arbiter #(
    parameter int LINES = arb_pkg::SNOOP_LINES
) (
    // Clock and reset.
    input  wire logic                            clk_sys,
    input  wire logic                            reset,
    // Active-low requests from external masters.
    input  wire logic                            general_bus_request_n,
    input  wire logic                            dual_bus_request_n,
    input  wire logic                            priority_general_request_n,
    input  wire logic                            priority_dual_request_n,
    input  wire logic                            owner_active_n,
    // Core's own need for the bus, active high.
    input  wire logic                            core_steal,
    // Snoop inputs from the owning master.
    input  wire logic                            snoop_strobe_n,
    input  wire logic [arb_pkg::ADDR_W-1:0]      bus_address,
    // Cache fill port from the core.
    input  wire logic                            fill_valid,
    input  wire logic [arb_pkg::ADDR_W-1:0]      fill_address,
    input  wire logic [$clog2(LINES)-1:0]        fill_index,
    // Active-low grants and release toward masters.
    output logic                                 general_bus_grant_n,
    output logic                                 dual_bus_grant_n,
    output logic                                 priority_general_grant_n,
    output logic                                 priority_dual_grant_n,
    output logic                                 bus_release_request_n,
    // Snoop result and line valid vector.
    output logic                                 snoop_hit,
    output logic [LINES-1:0]                     line_valid
);
    import arb_pkg::*;

    localparam int TAG_W = ADDR_W - LINE_LSB;

    // Whole state of the arbiter.
    typedef struct packed {
        owner_e owner;
        logic   gnt_gen;
        logic   gnt_dual;
        logic   gnt_pgen;
        logic   gnt_pdual;
        logic   rel;
        logic   snoop_go;
        logic [TAG_W-1:0] snoop_tag;
    } arb_s;

    arb_s st;
    arb_s next_st;

    // Picks the highest pending external requester for an idle bus.
    function automatic owner_e pick(input logic pd, input logic pg,
                                    input logic d, input logic g);
        if (pd) begin
            pick = OWN_PDUAL;
        end else if (pg) begin
            pick = OWN_PGEN;
        end else if (d) begin
            pick = OWN_DUAL;
        end else if (g) begin
            pick = OWN_GEN;
        end else begin
            pick = OWN_CORE;
        end
    endfunction

    // Decoded request levels, active high inside.
    logic rq_g;
    logic rq_d;
    logic rq_pg;
    logic rq_pd;
    logic active;
    logic outranked;

    // Active-low pins are inverted once here.
    always_comb begin
        rq_g   = (general_bus_request_n == ACT);
        rq_d   = (dual_bus_request_n == ACT);
        rq_pg  = (priority_general_request_n == ACT);
        rq_pd  = (priority_dual_request_n == ACT);
        active = (owner_active_n == ACT);
    end

    // Whether a pending request outranks the current external owner.
    always_comb begin
        case (st.owner)
            OWN_GEN:   outranked = rq_pd || core_steal || rq_pg
                                   || rq_d;
            OWN_DUAL:  outranked = rq_pd || rq_pg;
            OWN_PGEN:  outranked = rq_pd || core_steal;
            OWN_PDUAL: outranked = 1'h0;
            default:   outranked = 1'h0;
        endcase
    end

    // Ownership sequence: idle grant, release, wait for owner to finish,
    // then one cycle back at the core before the next grant, which
    // gives the dead cycle the masters expect.
    always_comb begin
        next_st = st;
        next_st.snoop_go = 1'h0;
        if (st.owner == OWN_CORE) begin
            next_st.rel = 1'h0;
            // The top request outranks the core's own cycle steal.
            if (rq_pd) begin
                next_st.owner = OWN_PDUAL;
            end else if (!core_steal) begin
                next_st.owner = pick(rq_pd, rq_pg, rq_d, rq_g);
            end
        end else if (!active && st.rel) begin
            // Owner has let go after a release; return to the core.
            next_st.owner = OWN_CORE;
            next_st.rel   = 1'h0;
        end else if (!active && !outranked && st.owner == OWN_GEN
                     && !rq_g) begin
            next_st.owner = OWN_CORE;
        end else if (!active && st.owner != OWN_GEN
                     && !(rq_pd || rq_pg || rq_d)) begin
            // Owner finished with its request withdrawn.
            next_st.owner = OWN_CORE;
        end else begin
            next_st.rel = outranked;
        end
        // Grant outputs follow the owner; none set means the core.
        next_st.gnt_gen   = (next_st.owner == OWN_GEN);
        next_st.gnt_dual  = (next_st.owner == OWN_DUAL);
        next_st.gnt_pgen  = (next_st.owner == OWN_PGEN);
        next_st.gnt_pdual = (next_st.owner == OWN_PDUAL);
        // Strobe taken every edge but only acted on under a dual grant.
        if ((st.gnt_dual || st.gnt_pdual)
            && snoop_strobe_n == ACT) begin
            next_st.snoop_go  = 1'h1;
            next_st.snoop_tag = bus_address[ADDR_W-1:LINE_LSB];
        end
    end

    // One register stage for the whole state.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Pins are driven active low straight from flip-flops.
    always_comb begin
        general_bus_grant_n      = ~st.gnt_gen;
        dual_bus_grant_n         = ~st.gnt_dual;
        priority_general_grant_n = ~st.gnt_pgen;
        priority_dual_grant_n    = ~st.gnt_pdual;
        bus_release_request_n    = ~st.rel;
    end

    // Tag store looked up with the registered snoop address.
    snoop_tags #(
        .LINES (LINES),
        .TAG_W (TAG_W)
    ) u_tags (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .fill_valid (fill_valid),
        .fill_tag   (fill_address[ADDR_W-1:LINE_LSB]),
        .fill_index (fill_index),
        .lookup     (st.snoop_go),
        .lookup_tag (st.snoop_tag),
        .hit        (snoop_hit),
        .valid      (line_valid)
    );
endmodule

// ### arb_props.sv
`timescale 1ns/1ps
// Timing checks on the arbiter and snoop ports.
module arb_props #(parameter int LINES = 16) (
    // Clock and reset.
    input wire logic             clk_sys, reset,
    // Requests and core need.
    input wire logic             general_bus_request_n, dual_bus_request_n,
    input wire logic             priority_general_request_n, core_steal,
    input wire logic             priority_dual_request_n, owner_active_n,
    input wire logic             snoop_strobe_n, snoop_hit,
    // Grants and release.
    input wire logic             general_bus_grant_n, dual_bus_grant_n,
    input wire logic             priority_general_grant_n,
    input wire logic             priority_dual_grant_n, bus_release_request_n,
    input wire logic [LINES-1:0] line_valid
);
    // High while the core owns the bus.
    wire logic idle = general_bus_grant_n & dual_bus_grant_n &
        priority_general_grant_n & priority_dual_grant_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_ONE_OWNER: assert property ($onehot0(~{general_bus_grant_n,
        dual_bus_grant_n, priority_general_grant_n, priority_dual_grant_n}))
        else $error("two grants active");
    AST_IDLE_PDUAL: assert property (idle && !priority_dual_request_n
        |=> !priority_dual_grant_n) else $error("top request not granted");
    AST_IDLE_STEAL: assert property (idle && core_steal &&
        priority_dual_request_n |=> idle) else $error("steal lost bus");
    AST_IDLE_PGEN: assert property (idle && priority_dual_request_n &&
        !core_steal && !priority_general_request_n
        |=> !priority_general_grant_n) else $error("pgen not granted");
    AST_REL_RAISE: assert property (!general_bus_grant_n &&
        !priority_general_request_n && !owner_active_n &&
        bus_release_request_n |=> !bus_release_request_n)
        else $error("no release");
    AST_GEN_KEEP: assert property (!general_bus_grant_n &&
        !general_bus_request_n && !owner_active_n && !core_steal &&
        bus_release_request_n && priority_general_request_n &&
        dual_bus_request_n && priority_dual_request_n
        |=> !general_bus_grant_n && bus_release_request_n)
        else $error("general owner lost bus");
    AST_DUAL_HOLD: assert property (!dual_bus_grant_n &&
        bus_release_request_n && priority_dual_request_n &&
        priority_general_request_n |=> bus_release_request_n)
        else $error("dual owner preempted");
    AST_PDUAL_HOLD: assert property (!priority_dual_grant_n
        |-> bus_release_request_n) else $error("pdual owner preempted");
    AST_REL_DROP: assert property (!bus_release_request_n &&
        owner_active_n |=> bus_release_request_n && idle)
        else $error("release held");
    AST_SNOOP_SRC: assert property (snoop_hit |-> $past(!snoop_strobe_n &&
        !(dual_bus_grant_n && priority_dual_grant_n), 2))
        else $error("snoop without valid strobe");
    AST_RESET: assert property (disable iff (1'b0) reset
        |=> idle && bus_release_request_n && line_valid == '0)
        else $error("reset state wrong");
endmodule
bind bus_arbiter arb_props #(.LINES(LINES)) prop_u (.*);

// ### dma_master_model.sv
`timescale 1ns/1ps
// External dual-bus master: asks for the bus, writes every held cycle.
module dma_master_model (
    input  wire logic        clk_sys,
    input  wire logic        want,
    input  wire logic        grant_n,
    input  wire logic        release_n,
    input  wire logic [35:0] addr,
    output logic             request_n,
    output logic             owner_active_n,
    output logic             snoop_strobe_n,
    output logic [35:0]      bus_address
);
    int beats;
    // Each held cycle is a write, so the strobe follows ownership.
    assign snoop_strobe_n = owner_active_n;
    // Idle address is inverted so a stale value never matches.
    assign bus_address = owner_active_n ? ~addr : addr;
    initial begin
        request_n = 1'h1;
        owner_active_n = 1'h1;
        beats = 0;
    end
    // Three beats, or fewer when released; request drops with active.
    always @(posedge clk_sys) begin
        if (!owner_active_n && (!release_n || beats == 3)) begin
            request_n <= 1'h1;
            owner_active_n <= 1'h1;
        end else if (!grant_n && !request_n) begin
            owner_active_n <= 1'h0;
            beats <= beats + 1;
        end else if (grant_n) begin
            request_n <= !want;
            beats <= 0;
        end
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import arb_pkg::*;
    logic        clk_sys = 1'h0;
    logic        reset = 1'h1;
    logic        gen_n = 1'h1, pgen_n = 1'h1, pdual_n = 1'h1, act_n = 1'h1;
    logic        steal = 1'h0, want = 1'h0, fill_v = 1'h0;
    logic [35:0] fill_a = 36'h0, snp_a = 36'h0;
    logic [3:0]  fill_i = 4'h0;
    wire logic   dreq_n, mact_n, strb_n, hit;
    wire logic [35:0] bus_a;
    wire logic [4:0]  outs; // release, pdual, pgen, dual, general grant
    wire logic [15:0] valid;
    int          fail_count = 0, check_count = 0, hit_cnt = 0;
    always #20 clk_sys = ~clk_sys;
    // Counts snoop hit pulses so a one-cycle result is never missed.
    always @(posedge clk_sys) begin
        if (hit === 1'h1) begin
            hit_cnt <= hit_cnt + 1;
        end
    end
    bus_arbiter dut_u (.clk_sys(clk_sys), .reset(reset),
        .general_bus_request_n(gen_n), .dual_bus_request_n(dreq_n),
        .priority_general_request_n(pgen_n), .core_steal(steal),
        .priority_dual_request_n(pdual_n), .owner_active_n(mact_n & act_n),
        .snoop_strobe_n(strb_n), .bus_address(bus_a), .fill_valid(fill_v),
        .fill_address(fill_a), .fill_index(fill_i),
        .general_bus_grant_n(outs[0]), .dual_bus_grant_n(outs[1]),
        .priority_general_grant_n(outs[2]), .priority_dual_grant_n(outs[3]),
        .bus_release_request_n(outs[4]), .snoop_hit(hit), .line_valid(valid));
    dma_master_model mst_u (.clk_sys(clk_sys), .want(want),
        .grant_n(outs[1]), .release_n(outs[4]), .addr(snp_a),
        .request_n(dreq_n), .owner_active_n(mact_n),
        .snoop_strobe_n(strb_n), .bus_address(bus_a));
    task final_report;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for one output bit to reach a level.
    task wait_lvl(input int sel, input logic lvl);
        int n;
        n = 0;
        while (outs[sel] !== lvl && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 60) begin
            fail_count++;
            final_report();
        end
    endtask
    task t_snoop;
        fill_v = 1'h1;
        fill_a = 36'h812345660;
        fill_i = 4'h3;
        @(negedge clk_sys);
        fill_a = 36'h812345680;
        fill_i = 4'h5;
        @(negedge clk_sys);
        fill_v = 1'h0;
        snp_a = 36'h81234567C;
        want = 1'h1;
        wait_lvl(1, 1'h0);
        want = 1'h0;
        wait_lvl(1, 1'h1);
        check(36'(valid[3]), 36'h0);
        check(36'(valid[5]), 36'h1);
        check(36'(hit_cnt), 36'h1);
        $display("snoop test done");
    endtask
    task t_preempt;
        gen_n = 1'h0;
        wait_lvl(0, 1'h0);
        act_n = 1'h0;
        pgen_n = 1'h0;
        wait_lvl(4, 1'h0);
        act_n = 1'h1;
        gen_n = 1'h1;
        wait_lvl(2, 1'h0);
        check(36'(outs), 36'h1B);
        pgen_n = 1'h1;
        wait_lvl(2, 1'h1);
        $display("preempt test done");
    endtask
    task t_idle;
        gen_n = 1'h0;
        pdual_n = 1'h0;
        wait_lvl(3, 1'h0);
        check(36'(outs), 36'h17);
        act_n = 1'h0;
        pgen_n = 1'h0;
        steal = 1'h1;
        repeat (4) @(negedge clk_sys);
        check(36'(outs), 36'h17);
        act_n = 1'h1;
        pdual_n = 1'h1;
        pgen_n = 1'h1;
        wait_lvl(3, 1'h1);
        repeat (2) @(negedge clk_sys);
        check(36'(outs[0]), 36'h1);
        steal = 1'h0;
        wait_lvl(0, 1'h0);
        gen_n = 1'h1;
        wait_lvl(0, 1'h1);
        $display("idle priority test done");
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        check({4'h0, outs, valid, 11'h0}, {4'h0, 5'h1F, 27'h0});
        reset = 1'h0;
        @(negedge clk_sys);
        t_snoop();
        t_preempt();
        t_idle();
        final_report();
    end
endmodule
